// ---- design/wdpd_core.v ----
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ns
`include "wdpd_defines.vh"
module wdpd_core #(
   parameter PORT_W = 8,
   parameter IRQ_W = 4
) (
   // clock and reset
   input wire clk,
   input wire rst_b,
   // register port
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // core events
   input wire halt_exec,
   input wire wdog_clear_exec,
   input wire [IRQ_W-1:0] irq_flag,
   input wire [IRQ_W-1:0] irq_enable,
   input wire stack_full,
   // pins and oscillator ticks
   input wire [PORT_W-1:0] port_a_pin,
   input wire sub_clk_pin,
   input wire fast_osc_pin,
   input wire slow_crystal_sel,
   // clock gating and mode state
   output reg core_halted,
   output reg sys_clk_en,
   output reg sub_clk_en,
   output reg tbc_clk_en,
   output reg [1:0] power_mode,
   // wake and reset actions
   output reg wake_resume,
   output reg wake_irq_service,
   output reg pc_sp_reset,
   output reg device_reset,
   output wire fast_osc_stable_flag,
   output wire slow_osc_stable_flag
);
   localparam M_RUN = 2'h0;
   localparam M_IDLE_WITHOUT_CORE_CLOCK = 2'h1;
   localparam M_IDLE_WITH_CORE_CLOCK = 2'h2;
   localparam M_SLEEP = 2'h3;

   reg [7:0] wdog_ctrl;
   reg core_clock_keep_in_idle;
   reg watchdog_reg_reset_flag;
   reg idle_select;
   reg fast_wake_enable;
   reg [PORT_W-1:0] port_a_wake_enable;
   reg power_down_flag;
   reg watchdog_expiry_flag;
   reg [17:0] wdog_cnt;
   reg [IRQ_W-1:0] irq_armed;
   reg [PORT_W-1:0] port_prev;
   reg sub_prev;
   reg fast_prev;
   reg [1:0] key_wait;
   reg key_bad_pend;
   reg wake_pend;
   reg wake_seen;
   reg [17:0] next_limit;
   wire [PORT_W-1:0] port_s;
   wire sub_s;
   wire fast_s;
   wire [4:0] key;
   wire wdog_on;
   wire sub_tick;
   wire fast_tick;
   wire wr_ctrl;
   wire key_bad;
   wire halt_go;
   wire wdog_ovf;
   wire port_wake;
   wire [IRQ_W-1:0] irq_wake;
   wire asleep;

   // pins pass two flops before use
   wdpd_sync #(.W(PORT_W + 2)) u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .d({port_a_pin, sub_clk_pin, fast_osc_pin}),
      .q({port_s, sub_s, fast_s})
   );

   // start-up counter shared by fast and slow oscillators
   wdpd_sst u_sst (
      .clk(clk),
      .rst_b(rst_b),
      .start(wake_pend & (power_mode == M_SLEEP)),
      .slow_needed(slow_crystal_sel),
      .fast_tick(fast_tick),
      .slow_tick(sub_tick),
      .fast_stable(fast_osc_stable_flag),
      .slow_stable(slow_osc_stable_flag)
   );

   assign key = wdog_ctrl[`WDPD_KEY_MSB:`WDPD_KEY_LSB];
   assign wdog_on = (key != `WDPD_KEY_OFF);
   assign key_bad = (key != `WDPD_KEY_OFF) && (key != `WDPD_KEY_ON);
   assign sub_tick = sub_s & ~sub_prev;
   assign fast_tick = fast_s & ~fast_prev;
   assign wr_ctrl = reg_wr && (reg_addr == `WDPD_ADDR_WDOG_CTRL);
   assign asleep = (power_mode != M_RUN);
   assign halt_go = halt_exec && !asleep;
   assign wdog_ovf = wdog_on && sub_tick && (wdog_cnt == next_limit);
   assign port_wake = |(port_a_wake_enable & port_prev & ~port_s);
   assign irq_wake = irq_flag & irq_armed;

   // timeout count chosen by the period field
   always @* begin
      case (wdog_ctrl[`WDPD_PER_MSB:`WDPD_PER_LSB])
         3'h0: next_limit = 18'h000FF;
         3'h1: next_limit = 18'h003FF;
         3'h2: next_limit = 18'h00FFF;
         3'h3: next_limit = 18'h03FFF;
         3'h4: next_limit = 18'h07FFF;
         3'h5: next_limit = 18'h0FFFF;
         3'h6: next_limit = 18'h1FFFF;
         default: next_limit = 18'h3FFFF;
      endcase
   end

   // edge history of the synchronised pins
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         port_prev <= {PORT_W{1'b0}}; // same as synchroniser, no false edge
         sub_prev <= 1'b0;
         fast_prev <= 1'b0;
      end else begin
         port_prev <= port_s;
         sub_prev <= sub_s;
         fast_prev <= fast_s;
      end
   end

   // software registers
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wdog_ctrl <= `WDPD_WDOG_CTRL_RST;
         core_clock_keep_in_idle <= 1'b0;
         idle_select <= 1'b0;
         fast_wake_enable <= 1'b0;
         port_a_wake_enable <= {PORT_W{1'b0}};
      end else begin
         if (wr_ctrl) begin
            wdog_ctrl <= reg_wdata;
         end
         if (reg_wr && reg_addr == `WDPD_ADDR_SYS_FLAGS) begin
            core_clock_keep_in_idle <= reg_wdata[`WDPD_CLK_KEEP_BIT];
         end
         if (reg_wr && reg_addr == `WDPD_ADDR_MODE) begin
            idle_select <= reg_wdata[`WDPD_IDLE_SEL_BIT];
            fast_wake_enable <= reg_wdata[`WDPD_FAST_WAKE_BIT];
         end
         if (reg_wr && reg_addr == `WDPD_ADDR_WAKE_EN) begin
            port_a_wake_enable <= reg_wdata[PORT_W-1:0];
         end
      end
   end

   // register reset flag: key reset sets, a written zero clears, set wins
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         watchdog_reg_reset_flag <= 1'b0;
      end else if (key_bad_pend && key_wait == `WDPD_KEY_RST_SUB) begin
         watchdog_reg_reset_flag <= 1'b1;
      end else if (reg_wr && reg_addr == `WDPD_ADDR_SYS_FLAGS &&
                   !reg_wdata[`WDPD_WREG_RST_BIT]) begin
         watchdog_reg_reset_flag <= 1'b0;
      end
   end

   // invalid key: count slow cycles, then reset the device
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         key_bad_pend <= 1'b0;
         key_wait <= 2'h0;
         device_reset <= 1'b0;
      end else begin
         device_reset <= 1'b0;
         if (!key_bad) begin
            key_bad_pend <= 1'b0;
            key_wait <= 2'h0;
         end else if (!key_bad_pend) begin
            key_bad_pend <= 1'b1;
            key_wait <= 2'h0;
         end else if (key_wait == `WDPD_KEY_RST_SUB) begin
            device_reset <= 1'b1;
            key_bad_pend <= 1'b0;
            key_wait <= 2'h0;
         end else if (sub_tick) begin
            key_wait <= key_wait + 2'h1;
         end
         if (wdog_ovf && !asleep) begin
            device_reset <= 1'b1;
         end
      end
   end

   // watchdog counter on the slow sub-clock
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wdog_cnt <= 18'h00000;
      end else if (key_bad || wdog_clear_exec || halt_go) begin
         wdog_cnt <= 18'h00000;
      end else if (wdog_ovf) begin
         wdog_cnt <= 18'h00000;
      end else if (wdog_on && sub_tick) begin
         wdog_cnt <= wdog_cnt + 18'h00001;
      end
   end

   // power-down and expiry flags
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         power_down_flag <= 1'b0;
         watchdog_expiry_flag <= 1'b0;
      end else begin
         if (halt_go) begin
            power_down_flag <= 1'b1;
         end else if (wdog_clear_exec) begin
            power_down_flag <= 1'b0;
         end
         if (wdog_ovf) begin
            watchdog_expiry_flag <= 1'b1;
         end else if (halt_go) begin
            watchdog_expiry_flag <= 1'b0;
         end
      end
   end

   // mode state, clock gating and wake-up
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         power_mode <= M_RUN;
         irq_armed <= {IRQ_W{1'b0}};
         wake_pend <= 1'b0;
         wake_seen <= 1'b0;
         core_halted <= 1'b0;
         sys_clk_en <= 1'b1;
         sub_clk_en <= 1'b1;
         tbc_clk_en <= 1'b1;
         wake_resume <= 1'b0;
         wake_irq_service <= 1'b0;
         pc_sp_reset <= 1'b0;
      end else begin
         wake_resume <= 1'b0;
         wake_irq_service <= 1'b0;
         pc_sp_reset <= 1'b0;
         // one cycle late copy lets the restarted start-up counter settle
         wake_seen <= wake_pend;
         if (halt_go) begin
            irq_armed <= ~irq_flag;
            core_halted <= 1'b1;
            if (idle_select && !core_clock_keep_in_idle) begin
               power_mode <= M_IDLE_WITHOUT_CORE_CLOCK;
               sys_clk_en <= 1'b0;
               sub_clk_en <= 1'b1;
               tbc_clk_en <= 1'b1;
            end else if (idle_select) begin
               power_mode <= M_IDLE_WITH_CORE_CLOCK;
               sys_clk_en <= 1'b1;
               sub_clk_en <= 1'b1;
               tbc_clk_en <= 1'b1;
            end else begin
               power_mode <= M_SLEEP;
               sys_clk_en <= 1'b0;
               sub_clk_en <= wdog_on;
               tbc_clk_en <= 1'b0;
            end
         end else if (asleep && !wake_pend &&
                      (port_wake || (|irq_wake) || wdog_ovf)) begin
            wake_pend <= 1'b1;
            pc_sp_reset <= wdog_ovf;
            wake_irq_service <= !wdog_ovf &&
               (|(irq_wake & irq_enable)) && !stack_full;
            wake_resume <= !wdog_ovf && !((|(irq_wake & irq_enable)) &&
               !stack_full);
         end else if (wake_pend && (power_mode != M_SLEEP || (wake_seen &&
                      (fast_osc_stable_flag || fast_wake_enable)))) begin
            // system clock returns with the mode, never while still idle
            wake_pend <= 1'b0;
            power_mode <= M_RUN;
            core_halted <= 1'b0;
            sys_clk_en <= 1'b1;
            sub_clk_en <= 1'b1;
            tbc_clk_en <= 1'b1;
         end
      end
   end

   // read data one cycle after the strobe
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `WDPD_ADDR_WDOG_CTRL: reg_rdata <= wdog_ctrl;
            `WDPD_ADDR_SYS_FLAGS: reg_rdata <= {core_clock_keep_in_idle,
               6'h00, watchdog_reg_reset_flag};
            `WDPD_ADDR_STATUS: reg_rdata <= {4'h0, slow_osc_stable_flag,
               fast_osc_stable_flag, watchdog_expiry_flag, power_down_flag};
            `WDPD_ADDR_MODE: reg_rdata <= {6'h00, fast_wake_enable,
               idle_select};
            `WDPD_ADDR_WAKE_EN: reg_rdata <= {{(8-PORT_W){1'b0}},
               port_a_wake_enable};
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule

// ---- design/wdpd_defines.vh ----
`ifndef WDPD_DEFINES_VH
`define WDPD_DEFINES_VH
// register addresses (index of each byte register)
`define WDPD_ADDR_WDOG_CTRL 4'h0
`define WDPD_ADDR_SYS_FLAGS 4'h1
`define WDPD_ADDR_STATUS 4'h2
`define WDPD_ADDR_MODE 4'h3
`define WDPD_ADDR_WAKE_EN 4'h4
// reset values
`define WDPD_WDOG_CTRL_RST 8'h53
`define WDPD_SYS_FLAGS_RST 8'h00
`define WDPD_MODE_RST 8'h00
`define WDPD_WAKE_EN_RST 8'h00
// field positions
`define WDPD_KEY_MSB 7
`define WDPD_KEY_LSB 3
`define WDPD_PER_MSB 2
`define WDPD_PER_LSB 0
`define WDPD_CLK_KEEP_BIT 7
`define WDPD_WREG_RST_BIT 0
`define WDPD_IDLE_SEL_BIT 0
`define WDPD_FAST_WAKE_BIT 1
// key codes
`define WDPD_KEY_OFF 5'h15
`define WDPD_KEY_ON 5'h0A
// invalid-key reset delay in slow clock cycles (1 to 2)
`define WDPD_KEY_RST_SUB 2'h2
// oscillator start-up periods in their own clock cycles
`define WDPD_FAST_SST_CYC 16'h0080
`define WDPD_SLOW_SST_CYC 16'h0080
`endif

// ---- design/wdpd_sst.v ----
`timescale 1ns/1ns
`include "wdpd_defines.vh"
// shared oscillator start-up counter: fast period first, then slow
module wdpd_sst (
   // clock and reset
   input wire clk,
   input wire rst_b,
   // control
   input wire start,
   input wire slow_needed,
   input wire fast_tick,
   input wire slow_tick,
   // status
   output reg fast_stable,
   output reg slow_stable
);
   localparam S_IDLE = 2'h0;
   localparam S_FAST = 2'h1;
   localparam S_SLOW = 2'h2;
   reg [1:0] state;
   reg [15:0] cnt;

   // one counter serves both oscillators in turn
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= S_FAST;
         cnt <= 16'h0000;
         fast_stable <= 1'b0;
         slow_stable <= 1'b0;
      end else begin
         case (state)
            S_IDLE: begin
               if (start) begin
                  state <= S_FAST;
                  cnt <= 16'h0000;
                  fast_stable <= 1'b0;
                  slow_stable <= ~slow_needed;
               end
            end
            S_FAST: begin
               if (fast_tick) begin
                  if (cnt == `WDPD_FAST_SST_CYC - 16'h0001) begin
                     fast_stable <= 1'b1;
                     cnt <= 16'h0000;
                     state <= S_SLOW;
                  end else begin
                     cnt <= cnt + 16'h0001;
                  end
               end
            end
            S_SLOW: begin
               if (slow_stable) begin
                  state <= S_IDLE;
               end else if (slow_tick) begin
                  if (cnt == `WDPD_SLOW_SST_CYC - 16'h0001) begin
                     slow_stable <= 1'b1;
                     state <= S_IDLE;
                  end else begin
                     cnt <= cnt + 16'h0001;
                  end
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end
endmodule

// ---- design/wdpd_sync.v ----
`timescale 1ns/1ns
// two-flop synchroniser for a bus of levels
module wdpd_sync #(
   parameter W = 1
) (
   // clock and reset
   input wire clk,
   input wire rst_b,
   // data
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] meta;

   // first stage is read only by the second
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta <= {W{1'b0}};
         q <= {W{1'b0}};
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/1ns
`include "wdpd_defines.vh"
module testbench;
   reg clk = 1'b0;
   reg rst_b = 1'b0;
   reg [3:0] reg_addr = 4'h0;
   reg [7:0] reg_wdata = 8'h00;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg halt_exec = 1'b0;
   reg wdog_clear_exec = 1'b0;
   reg [3:0] irq_flag = 4'h0;
   reg [3:0] irq_enable = 4'h0;
   reg stack_full = 1'b0;
   reg [7:0] port_a_pin = 8'hFF;
   reg sub_clk_pin = 1'b0;
   reg fast_osc_pin = 1'b0;
   reg slow_crystal_sel = 1'b1;
   wire [7:0] reg_rdata;
   wire core_halted, sys_clk_en, sub_clk_en, tbc_clk_en;
   wire [1:0] power_mode;
   wire wake_resume, wake_irq_service, pc_sp_reset, device_reset;
   wire fast_osc_stable_flag, slow_osc_stable_flag;
   wire [3:0] ev = {device_reset, pc_sp_reset, wake_irq_service, wake_resume};
   wire [5:0] ms = {core_halted, power_mode, sys_clk_en, sub_clk_en,
      tbc_clk_en};
   int fail_count = 0, n_compared = 0, cyc = 0, t0, el, ex, k;
   int wexp[8] = '{8, 10, 12, 14, 15, 16, 17, 18};
   reg [15:0] exp_q[$];
   reg [15:0] e;
   reg rd_d = 1'b0;

   wdpd_core #(.PORT_W(8), .IRQ_W(4)) i_wdpd_core (.clk, .rst_b, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .halt_exec, .wdog_clear_exec,
      .irq_flag, .irq_enable, .stack_full, .port_a_pin, .sub_clk_pin,
      .fast_osc_pin, .slow_crystal_sel, .core_halted, .sys_clk_en,
      .sub_clk_en, .tbc_clk_en, .power_mode, .wake_resume, .wake_irq_service,
      .pc_sp_reset, .device_reset, .fast_osc_stable_flag,
      .slow_osc_stable_flag);

   // system clock, 8 ns
   always #4 clk = ~clk;

   // slow sub-clock of 8 cycles, fast oscillator of 4, and hang limit
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc % 4 == 3) sub_clk_pin <= ~sub_clk_pin;
      if (cyc % 2 == 1) fast_osc_pin <= ~fast_osc_pin;
      if (cyc > 40000) begin
         fail_count++;
         complete_run;
      end
   end

   // read data is compared with the oldest note of the queue
   always @(posedge clk) begin
      rd_d <= reg_rd;
      if (rd_d) begin
         e = exp_q.pop_front();
         check("read data", e[7:0], reg_rdata & e[15:8]);
      end
   end

   task check(input string nm, input [15:0] x, input [15:0] g);
      n_compared++;
      if (g !== x) begin
         $display("mismatch %s expected %h seen %h", nm, x, g);
         fail_count++;
      end
   endtask

   task wr(input [3:0] a, input [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task rd(input [3:0] a, input [7:0] x, input [7:0] m);
      exp_q.push_back({m, x & m});
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
   endtask

   // one-cycle instruction: 1 watchdog clear, 0 halt
   task ins(input bit c);
      @(posedge clk);
      if (c) wdog_clear_exec <= 1'b1;
      else halt_exec <= 1'b1;
      @(posedge clk);
      wdog_clear_exec <= 1'b0;
      halt_exec <= 1'b0;
      @(posedge clk);
      #1;
   endtask

   // wait a bounded time for one event pulse
   task wait_ev(input int b, input int lim, input bit want);
      bit seen;
      seen = 1'b0;
      t0 = cyc;
      while (!seen && cyc - t0 < lim) begin
         @(posedge clk);
         #1;
         if (ev[b] === 1'b1) seen = 1'b1;
      end
      el = cyc - t0;
      check("event", want, seen);
   endtask

   task wait_run;
      t0 = cyc;
      while (power_mode !== 2'h0 && cyc - t0 < 3000) @(posedge clk);
      #1;
      check("run mode", 2'h0, power_mode);
   endtask

   task complete_run;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      void'($urandom(32'hdf8db594));
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      rd(`WDPD_ADDR_WDOG_CTRL, 8'h53, 8'hFF);
      rd(`WDPD_ADDR_SYS_FLAGS, 8'h00, 8'h81);
      rd(`WDPD_ADDR_STATUS, 8'h00, 8'h03);
      rd(4'hF, 8'h00, 8'hFF);
      k = $urandom;
      wr(`WDPD_ADDR_WAKE_EN, k[7:0]);
      rd(`WDPD_ADDR_WAKE_EN, k[7:0], 8'hFF);
      // idle without core clock, woken by an enabled pin only
      wr(`WDPD_ADDR_WAKE_EN, 8'h01);
      wr(`WDPD_ADDR_MODE, 8'h01);
      wr(`WDPD_ADDR_SYS_FLAGS, 8'h00);
      wr(`WDPD_ADDR_WDOG_CTRL, 8'hA8);
      ins(0);
      check("idle gating", 6'b101011, ms);
      rd(`WDPD_ADDR_STATUS, 8'h01, 8'h03);
      @(posedge clk) port_a_pin <= 8'hFD;
      wait_ev(0, 20, 1'b0);
      @(posedge clk) port_a_pin <= 8'hFC;
      wait_ev(0, 20, 1'b1);
      @(posedge clk) port_a_pin <= 8'hFF;
      wait_run;
      // idle with core clock, interrupt wake in three situations
      wr(`WDPD_ADDR_SYS_FLAGS, 8'h80);
      for (k = 0; k < 3; k++) begin
         @(posedge clk);
         irq_enable <= (k == 1) ? 4'h0 : 4'hF;
         stack_full <= (k == 2);
         ins(0);
         if (k == 0) check("idle_with_core_clock gating", 6'b110111, ms);
         @(posedge clk) irq_flag <= 4'h2;
         wait_ev(k == 0 ? 1 : 0, 20, 1'b1);
         @(posedge clk) irq_flag <= 4'h0;
         wait_run;
      end
      // a flag pending before halt does not wake
      @(posedge clk) irq_flag <= 4'h4;
      ins(0);
      wait_ev(1, 30, 1'b0);
      check("still idle", 2'h2, power_mode);
      @(posedge clk) port_a_pin <= 8'hFE;
      wait_ev(0, 20, 1'b1);
      @(posedge clk) port_a_pin <= 8'hFF;
      irq_flag <= 4'h0;
      wait_run;
      // watchdog overflow in sleep; halt restarts the count
      wr(`WDPD_ADDR_MODE, 8'h00);
      wr(`WDPD_ADDR_WDOG_CTRL, 8'h50);
      ins(1);
      repeat (1000) @(posedge clk);
      ins(0);
      check("sleep", 2'h3, power_mode);
      check("sleep gating", 6'b111010, ms);
      wait_ev(2, 2400, 1'b1);
      ex = (1 << wexp[0]) * 8;
      check("sleep timeout", 1, el > ex - 32 && el < ex + 32);
      wait_run;
      rd(`WDPD_ADDR_STATUS, 8'h03, 8'h03);
      ins(1);
      rd(`WDPD_ADDR_STATUS, 8'h00, 8'h01);
      // normal timeouts for two period codes
      for (k = 0; k < 2; k++) begin
         wr(`WDPD_ADDR_WDOG_CTRL, 8'h50 | k[7:0]);
         ins(1);
         wait_ev(3, 9000, 1'b1);
         ex = (1 << wexp[k]) * 8;
         check("timeout", 1, el > ex - 32 && el < ex + 32);
      end
      rd(`WDPD_ADDR_STATUS, 8'h02, 8'h02);
      // disabled watchdog, then an invalid key
      wr(`WDPD_ADDR_WDOG_CTRL, 8'hA8);
      ins(1);
      wait_ev(3, 2400, 1'b0);
      wr(`WDPD_ADDR_WDOG_CTRL, 8'h00);
      wait_ev(3, 40, 1'b1);
      wr(`WDPD_ADDR_WDOG_CTRL, 8'hA8);
      rd(`WDPD_ADDR_SYS_FLAGS, 8'h01, 8'h01);
      wr(`WDPD_ADDR_SYS_FLAGS, 8'h01);
      rd(`WDPD_ADDR_SYS_FLAGS, 8'h01, 8'h01);
      wr(`WDPD_ADDR_SYS_FLAGS, 8'h00);
      rd(`WDPD_ADDR_SYS_FLAGS, 8'h00, 8'h01);
      rd(`WDPD_ADDR_STATUS, 8'h0C, 8'h0C);
      wr(`WDPD_ADDR_MODE, 8'h02);
      rd(`WDPD_ADDR_MODE, 8'h02, 8'h03);
      complete_run;
   end
endmodule

// ---- verif/wdpd_core_assertions.sv ----
`timescale 1ns/1ns
module wdpd_core_assertions (
   // clock and reset
   input wire clk,
   input wire rst_b,
   // core events
   input wire halt_exec,
   input wire stack_full,
   // mode and actions
   input wire core_halted,
   input wire sys_clk_en,
   input wire sub_clk_en,
   input wire tbc_clk_en,
   input wire [1:0] power_mode,
   input wire wake_resume,
   input wire wake_irq_service,
   input wire pc_sp_reset,
   input wire device_reset,
   input wire fast_osc_stable_flag
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   // steps of entering and leaving a low-power mode
   sequence s_halt_taken;
      halt_exec && power_mode == 2'h0;
   endsequence
   sequence s_low_power;
      core_halted && power_mode != 2'h0;
   endsequence
   sequence s_back_to_run;
      $past(power_mode) == 2'h3 && power_mode == 2'h0;
   endsequence

   // mode entry, gating and wake actions
   halt_enter_a: assert property (s_halt_taken |=> s_low_power)
      else $error("halt did not enter a low-power mode");
   idle_gate_a: assert property (power_mode == 2'h1 |->
      core_halted && !sys_clk_en && sub_clk_en && tbc_clk_en)
      else $error("idle without core clock gated wrongly");
   idle_keep_a: assert property (power_mode == 2'h2 |->
      core_halted && sys_clk_en && sub_clk_en && tbc_clk_en)
      else $error("idle with core clock gated wrongly");
   wake_source_a: assert property (wake_resume |->
      $past(power_mode) != 2'h0)
      else $error("resume pulse while running");
   wake_pulse_a: assert property (wake_resume |=> !wake_resume)
      else $error("resume pulse longer than one cycle");
   irq_service_a: assert property (wake_irq_service |->
      !$past(stack_full) && $past(power_mode) != 2'h0)
      else $error("interrupt service with full stack or awake");
   pcsp_asleep_a: assert property (pc_sp_reset |->
      $past(power_mode) != 2'h0 && !device_reset)
      else $error("counter and stack reset outside low power");
   key_pulse_a: assert property (device_reset |=> !device_reset)
      else $error("device reset longer than one cycle");
   sleep_exit_a: assert property (s_back_to_run |->
      fast_osc_stable_flag)
      else $error("left sleep before fast oscillator stable");
endmodule

bind wdpd_core wdpd_core_assertions i_wdpd_core_assertions (.clk, .rst_b,
   .halt_exec, .stack_full, .core_halted, .sys_clk_en, .sub_clk_en,
   .tbc_clk_en, .power_mode, .wake_resume, .wake_irq_service, .pc_sp_reset,
   .device_reset, .fast_osc_stable_flag);
